/* hssc_pkg.sv */
// package: register map, field layout and timing for the high-side switch control bank
package hssc_pkg;

  localparam logic [6:0] HSSC_ADDR_SHUTDOWN = 7'h10;
  localparam logic [6:0] HSSC_ADDR_SELECT_A = 7'h14;
  localparam logic [6:0] HSSC_ADDR_SELECT_B = 7'h15;
  localparam logic [6:0] HSSC_ADDR_PIN_FUNC = 7'h17;
  localparam logic [6:0] HSSC_ADDR_PULSE_CHANNEL_ONE_DUTY = 7'h18;

  localparam logic [7:0] HSSC_RESET_VALUE = 8'h00;
  localparam logic [7:0] HSSC_SHUTDOWN_MASK = 8'h70;
  localparam logic [7:0] HSSC_SELECT_MASK = 8'h77;
  localparam logic [7:0] HSSC_TIMER_MASK = 8'h77;

  localparam int HSSC_OV_DISABLE_BIT = 6;
  localparam int HSSC_UV_DISABLE_BIT = 5;
  localparam int HSSC_RECOVERY_BIT = 4;
  localparam int HSSC_LOW_FIELD_LSB = 0;
  localparam int HSSC_HIGH_FIELD_LSB = 4;
  localparam int HSSC_DUTY_FIELD_LSB = 6;
  localparam int HSSC_PIN2_FIELD_LSB = 3;
  localparam int HSSC_PIN1_FIELD_LSB = 0;
  localparam int HSSC_ON_TIME_LSB = 4;

  // switch source codes
  localparam logic [2:0] HSSC_SRC_OFF = 3'h0;
  localparam logic [2:0] HSSC_SRC_ON = 3'h1;
  localparam logic [2:0] HSSC_SRC_CYCLIC_TIMER_ONE = 3'h2;
  localparam logic [2:0] HSSC_SRC_CYCLIC_TIMER_TWO = 3'h3;
  localparam logic [2:0] HSSC_SRC_PULSE_CHANNEL_ONE = 3'h4;
  localparam logic [2:0] HSSC_SRC_PULSE_CHANNEL_TWO = 3'h5;

  // multi-function pin codes
  localparam logic [2:0] HSSC_PIN_OFF = 3'h4;
  localparam logic [2:0] HSSC_PIN_WAKE = 3'h5;
  localparam logic [2:0] HSSC_PIN_LOW_ON = 3'h6;
  localparam logic [2:0] HSSC_PIN_HIGH_ON = 3'h7;

  // timer on-time codes
  localparam logic [2:0] HSSC_ON_STOP_LOW = 3'h0;
  localparam logic [2:0] HSSC_ON_STOP_HIGH = 3'h6;
  localparam logic [2:0] HSSC_ON_RESERVED = 3'h7;

  localparam logic [7:0] HSSC_PWM_FULL = 8'hFF;

  // pwm timing: 200 Hz base period split into 255 steps
  localparam int HSSC_CLK_HZ = 40_000_000;
  localparam int HSSC_PWM_HZ = 200;
  localparam int HSSC_PWM_STEP_CYCLES = HSSC_CLK_HZ / (HSSC_PWM_HZ * 255);

  // wake filter on the multi-function pins
  localparam int HSSC_WAKE_FILTER_NS = 16_000;
  localparam int HSSC_CLK_PERIOD_NS = 25;
  localparam int HSSC_WAKE_FILTER_CYCLES =
    (HSSC_WAKE_FILTER_NS + HSSC_CLK_PERIOD_NS - 1) / HSSC_CLK_PERIOD_NS;

  localparam int HSSC_NUM_SWITCHES = 4;

endpackage : hssc_pkg

/* hssc_src_if.sv */
// interface: source levels offered to the switch selector
`timescale 1ns/10ps
interface hssc_src_if;
  logic [2:0] select_code;
  logic       cyclic_timer_one_level;
  logic       cyclic_timer_two_level;
  logic       pulse_channel_one_level;
  logic       pulse_channel_two_level;
  logic       drive;

  modport bank (output select_code, output cyclic_timer_one_level, output cyclic_timer_two_level,
                output pulse_channel_one_level, output pulse_channel_two_level, input drive);
  modport sel  (input select_code, input cyclic_timer_one_level, input cyclic_timer_two_level,
                input pulse_channel_one_level, input pulse_channel_two_level, output drive);
endinterface : hssc_src_if

/* hssc_switch_sel.sv */
// module: per-switch source selection, registered drive level
`timescale 1ns/10ps
module hssc_switch_sel
  import hssc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic blocked,
  hssc_src_if.sel   src
);

  logic drive_reg;
  logic drive_next;

  always_comb begin
    drive_next = 1'b0;
    if (!blocked) begin
      unique case (src.select_code)
        HSSC_SRC_OFF:    drive_next = 1'b0;
        HSSC_SRC_ON:     drive_next = 1'b1;
        HSSC_SRC_CYCLIC_TIMER_ONE: drive_next = src.cyclic_timer_one_level;
        HSSC_SRC_CYCLIC_TIMER_TWO: drive_next = src.cyclic_timer_two_level;
        HSSC_SRC_PULSE_CHANNEL_ONE:   drive_next = src.pulse_channel_one_level;
        HSSC_SRC_PULSE_CHANNEL_TWO:   drive_next = src.pulse_channel_two_level;
        default:         drive_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign src.drive = drive_reg;

endmodule : hssc_switch_sel

/* hssc_bank.sv */
// module: high-side switch control register bank and output logic
`timescale 1ns/10ps
// Function
// - timer runs only when assigned and on-time code 1..5
// - restart clearing switches also clears timer settings when cyclic sensing is active and a timer is assigned
// - overvoltage bit 6 zero turns switches off
// - undervoltage bit 5 zero turns switches off
// - recovery bit 4 restores state after supply fault
// - reserved bits read zero, ignore writes
// - select a fields: switch one, switch two
// - select b fields, cleared by every reset kind
// - overcurrent or overtemperature clears switch field
// - fail output duty bits 7:6 pick 20..2.5 percent
// - pin two function from bits 5:3
// - pin one function, kept through restart
// - pulse channel one duty value over 255
// - duty register cleared by reset, kept on restart
// - shutdown register keeps bits 6:4 on restart
// - on-time codes stop low, run, stop high
module hssc_bank
  import hssc_pkg::*;
#(
  parameter int STEP_CYCLES = HSSC_PWM_STEP_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       soft_reset,
  input  wire logic       restart_enter,
  input  wire logic       cyclic_sense_active,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  input  wire logic [7:0] cyclic_timer_one_ctrl_in,
  input  wire logic [7:0] cyclic_timer_two_ctrl_in,
  output logic            timer_clear,
  input  wire logic       cyclic_timer_one_level,
  input  wire logic       cyclic_timer_two_level,
  input  wire logic       pulse_channel_two_level,
  input  wire logic       supply_ov,
  input  wire logic       supply_uv,
  input  wire logic [3:0] switch_fault,
  output logic      [3:0] switch_drive,
  output logic      [3:0] timer_run,
  output logic            pulse_channel_one_level,
  output logic      [2:0] pin1_func,
  output logic      [2:0] pin2_func,
  output logic      [1:0] fail_output_duty,
  output logic            pin1_fail_select,
  output logic            pin2_fail_select
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]  shutdown_reg, shutdown_next;
  logic [7:0]  select_a_reg, select_a_next;
  logic [7:0]  select_b_reg, select_b_next;
  logic [7:0]  pin_func_reg, pin_func_next;
  logic [7:0]  duty_reg, duty_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  logic        rd_valid_reg, rd_valid_next;
  logic        timer_clear_reg, timer_clear_next;
  logic [15:0] saved_reg, saved_next;
  logic        fault_reg, fault_next;
  logic [2:0]  ov_sync_reg, uv_sync_reg;
  logic        ov_level_reg, uv_level_reg;

  function automatic logic is_timer_code(input logic [2:0] code, input logic [2:0] which);
    is_timer_code = (code == which);
  endfunction : is_timer_code

  function automatic logic [2:0] field_of(input logic [15:0] sel, input int idx);
    field_of = sel[idx*4 +: 3];
  endfunction : field_of

  function automatic logic [2:0] pin_code(input logic [7:0] r, input int lsb);
    pin_code = r[lsb +: 3];
  endfunction : pin_code

  // ----------------------------------------------------------------
  // supply fault inputs, three-stage synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ov_sync_reg  <= 3'h0;
      uv_sync_reg  <= 3'h0;
      ov_level_reg <= 1'b0;
      uv_level_reg <= 1'b0;
    end else begin
      ov_sync_reg <= {ov_sync_reg[1:0], supply_ov};
      uv_sync_reg <= {uv_sync_reg[1:0], supply_uv};
      if (ov_sync_reg[1] == ov_sync_reg[2]) begin
        ov_level_reg <= ov_sync_reg[2];
      end
      if (uv_sync_reg[1] == uv_sync_reg[2]) begin
        uv_level_reg <= uv_sync_reg[2];
      end
    end
  end

  logic ov_shut, uv_shut, supply_block;
  assign ov_shut = ov_level_reg && !shutdown_reg[HSSC_OV_DISABLE_BIT];
  assign uv_shut = uv_level_reg && !shutdown_reg[HSSC_UV_DISABLE_BIT];
  assign supply_block = ov_shut || uv_shut;

  // ----------------------------------------------------------------
  // register writes and hardware updates
  // ----------------------------------------------------------------
  logic [15:0] sel_cur;
  logic        any_timer_used;
  assign sel_cur = {select_b_reg, select_a_reg};

  always_comb begin
    shutdown_next    = shutdown_reg;
    select_a_next    = select_a_reg;
    select_b_next    = select_b_reg;
    pin_func_next    = pin_func_reg;
    duty_next        = duty_reg;
    saved_next       = saved_reg;
    fault_next       = supply_block;
    timer_clear_next = 1'b0;
    any_timer_used   = 1'b0;
    for (int i = 0; i < HSSC_NUM_SWITCHES; i++) begin
      if (is_timer_code(field_of(sel_cur, i), HSSC_SRC_CYCLIC_TIMER_ONE) ||
          is_timer_code(field_of(sel_cur, i), HSSC_SRC_CYCLIC_TIMER_TWO)) begin
        any_timer_used = 1'b1;
      end
    end
    if (wr_en) begin
      unique case (addr)
        HSSC_ADDR_SHUTDOWN:  shutdown_next = wr_data & HSSC_SHUTDOWN_MASK;
        HSSC_ADDR_SELECT_A:  select_a_next = wr_data & HSSC_SELECT_MASK;
        HSSC_ADDR_SELECT_B:  select_b_next = wr_data & HSSC_SELECT_MASK;
        HSSC_ADDR_PIN_FUNC:  pin_func_next = wr_data;
        HSSC_ADDR_PULSE_CHANNEL_ONE_DUTY: duty_next     = wr_data;
        default: ;
      endcase
    end
    // supply fault entry: remember the live selection
    if (supply_block && !fault_reg) begin
      saved_next = {select_b_next, select_a_next};
    end
    // supply fault left: restore or keep off
    if (!supply_block && fault_reg) begin
      if (shutdown_reg[HSSC_RECOVERY_BIT]) begin
        {select_b_next, select_a_next} = saved_reg;
      end else begin
        select_a_next = HSSC_RESET_VALUE;
        select_b_next = HSSC_RESET_VALUE;
      end
    end
    // hardware clear beats a simultaneous write
    for (int i = 0; i < HSSC_NUM_SWITCHES; i++) begin
      if (switch_fault[i]) begin
        if (i < 2) begin
          select_a_next[(i % 2)*4 +: 3] = HSSC_SRC_OFF;
        end else begin
          select_b_next[(i % 2)*4 +: 3] = HSSC_SRC_OFF;
        end
        saved_next[i*4 +: 3] = HSSC_SRC_OFF;
      end
    end
    if (restart_enter) begin
      shutdown_next = shutdown_reg & HSSC_SHUTDOWN_MASK;
      select_a_next = HSSC_RESET_VALUE;
      select_b_next = HSSC_RESET_VALUE;
      saved_next    = 16'h0000;
      // pin and duty registers hold through restart
      timer_clear_next = cyclic_sense_active && any_timer_used;
    end
    if (soft_reset) begin
      shutdown_next = HSSC_RESET_VALUE;
      select_a_next = HSSC_RESET_VALUE;
      select_b_next = HSSC_RESET_VALUE;
      pin_func_next = HSSC_RESET_VALUE;
      duty_next     = HSSC_RESET_VALUE;
      saved_next    = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_data_next  = rd_data_reg;
    rd_valid_next = rd_en;
    if (rd_en) begin
      unique case (addr)
        HSSC_ADDR_SHUTDOWN:  rd_data_next = shutdown_reg & HSSC_SHUTDOWN_MASK;
        HSSC_ADDR_SELECT_A:  rd_data_next = select_a_reg & HSSC_SELECT_MASK;
        HSSC_ADDR_SELECT_B:  rd_data_next = select_b_reg & HSSC_SELECT_MASK;
        HSSC_ADDR_PIN_FUNC:  rd_data_next = pin_func_reg;
        HSSC_ADDR_PULSE_CHANNEL_ONE_DUTY: rd_data_next = duty_reg;
        default:             rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shutdown_reg    <= HSSC_RESET_VALUE;
      select_a_reg    <= HSSC_RESET_VALUE;
      select_b_reg    <= HSSC_RESET_VALUE;
      pin_func_reg    <= HSSC_RESET_VALUE;
      duty_reg        <= HSSC_RESET_VALUE;
      saved_reg       <= 16'h0000;
      fault_reg       <= 1'b0;
      rd_data_reg     <= 8'h00;
      rd_valid_reg    <= 1'b0;
      timer_clear_reg <= 1'b0;
    end else begin
      shutdown_reg    <= shutdown_next;
      select_a_reg    <= select_a_next;
      select_b_reg    <= select_b_next;
      pin_func_reg    <= pin_func_next;
      duty_reg        <= duty_next;
      saved_reg       <= saved_next;
      fault_reg       <= fault_next;
      rd_data_reg     <= rd_data_next;
      rd_valid_reg    <= rd_valid_next;
      timer_clear_reg <= timer_clear_next;
    end
  end

  assign rd_data     = rd_data_reg;
  assign rd_valid    = rd_valid_reg;
  assign timer_clear = timer_clear_reg;

  // ----------------------------------------------------------------
  // pulse channel one generator
  // ----------------------------------------------------------------
  logic [15:0] step_reg, step_next;
  logic [7:0]  phase_reg, phase_next;
  logic        pwm_reg, pwm_next;

  always_comb begin
    step_next  = step_reg + 16'h0001;
    phase_next = phase_reg;
    if (step_reg >= 16'(STEP_CYCLES - 1)) begin
      step_next  = 16'h0000;
      // phase runs 0..254 so the period holds exactly 255 steps
      phase_next = (phase_reg == 8'hFE) ? 8'h00 : phase_reg + 8'h01;
    end
    if (duty_reg == HSSC_RESET_VALUE) begin
      pwm_next = 1'b0;
    end else if (duty_reg == HSSC_PWM_FULL) begin
      pwm_next = 1'b1;
    end else begin
      pwm_next = (phase_reg < duty_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      step_reg  <= 16'h0000;
      phase_reg <= 8'h00;
      pwm_reg   <= 1'b0;
    end else begin
      step_reg  <= step_next;
      phase_reg <= phase_next;
      pwm_reg   <= pwm_next;
    end
  end

  assign pulse_channel_one_level = pwm_reg;

  // ----------------------------------------------------------------
  // timer activation: assigned and on-time set
  // ----------------------------------------------------------------
  logic [2:0] t1_on, t2_on;
  logic       t1_used, t2_used;
  assign t1_on = cyclic_timer_one_ctrl_in[HSSC_ON_TIME_LSB +: 3];
  assign t2_on = cyclic_timer_two_ctrl_in[HSSC_ON_TIME_LSB +: 3];
  always_comb begin
    t1_used = 1'b0;
    t2_used = 1'b0;
    for (int i = 0; i < HSSC_NUM_SWITCHES; i++) begin
      t1_used = t1_used | is_timer_code(field_of(sel_cur, i), HSSC_SRC_CYCLIC_TIMER_ONE);
      t2_used = t2_used | is_timer_code(field_of(sel_cur, i), HSSC_SRC_CYCLIC_TIMER_TWO);
    end
  end
  // stop-low, stop-high and reserved codes never run
  assign timer_run[0] = t1_used && (t1_on != HSSC_ON_STOP_LOW) &&
                        (t1_on != HSSC_ON_STOP_HIGH) && (t1_on != HSSC_ON_RESERVED);
  assign timer_run[1] = t2_used && (t2_on != HSSC_ON_STOP_LOW) &&
                        (t2_on != HSSC_ON_STOP_HIGH) && (t2_on != HSSC_ON_RESERVED);
  assign timer_run[3:2] = 2'b00;

  // ----------------------------------------------------------------
  // switch selectors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < HSSC_NUM_SWITCHES; g++) begin : g_sw
      hssc_src_if s_if ();
      assign s_if.select_code  = field_of(sel_cur, g);
      assign s_if.cyclic_timer_one_level = cyclic_timer_one_level;
      assign s_if.cyclic_timer_two_level = cyclic_timer_two_level;
      assign s_if.pulse_channel_one_level   = pwm_reg;
      assign s_if.pulse_channel_two_level   = pulse_channel_two_level;
      hssc_switch_sel u_sel (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        // stay off until the restore or clear has landed after a supply fault
        .blocked (supply_block || fault_reg),
        .src     (s_if.sel)
      );
      assign switch_drive[g] = s_if.drive;
    end
  endgenerate

  // ----------------------------------------------------------------
  // multi-function pins
  // ----------------------------------------------------------------
  assign fail_output_duty = pin_func_reg[HSSC_DUTY_FIELD_LSB +: 2];
  assign pin2_func        = pin_code(pin_func_reg, HSSC_PIN2_FIELD_LSB);
  assign pin1_func        = pin_code(pin_func_reg, HSSC_PIN1_FIELD_LSB);
  assign pin2_fail_select = !pin_func_reg[HSSC_PIN2_FIELD_LSB + 2];
  assign pin1_fail_select = !pin_func_reg[HSSC_PIN1_FIELD_LSB + 2];

endmodule : hssc_bank

/* hssc_bank_properties.sv */
// checker: port-level properties of the high-side switch control bank
`timescale 1ns/10ps
module hssc_bank_chk
  import hssc_pkg::*;
#(
  parameter int STEP_CYCLES = HSSC_PWM_STEP_CYCLES
) (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       soft_reset,
  input wire logic       restart_enter,
  input wire logic       cyclic_sense_active,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid,
  input wire logic [7:0] cyclic_timer_one_ctrl_in,
  input wire logic       timer_clear,
  input wire logic       supply_ov,
  input wire logic       supply_uv,
  input wire logic [3:0] switch_fault,
  input wire logic [3:0] switch_drive,
  input wire logic [3:0] timer_run,
  input wire logic       pulse_channel_one_level,
  input wire logic [2:0] pin1_func,
  input wire logic       pin1_fail_select
);
  logic [1:0] sd_dis_reg;
  logic [7:0] duty_reg;
  // --------------------------------
  // shadows of written settings
  // --------------------------------
  // restart keeps both, so only the two resets clear them
  always_ff @(posedge clk_sys) begin
    if (!reset_n || soft_reset) begin
      sd_dis_reg <= 2'h0;
      duty_reg   <= 8'h00;
    end else if (wr_en && addr == HSSC_ADDR_SHUTDOWN) begin
      sd_dis_reg <= wr_data[6:5];
    end else if (wr_en && addr == HSSC_ADDR_PULSE_CHANNEL_ONE_DUTY) begin
      duty_reg <= wr_data;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_sd_reserved;
    rd_en && addr == HSSC_ADDR_SHUTDOWN |=> rd_valid && rd_data[7] == 1'b0 && rd_data[3:0] == 4'h0;
  endproperty
  a_sd_reserved: assert property (p_sd_reserved) else $error("shutdown reserved bits set");
  property p_sel_reserved;
    rd_en && addr == HSSC_ADDR_SELECT_A |=> rd_valid && rd_data[7] == 1'b0 && rd_data[3] == 1'b0;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved) else $error("select reserved bits set");
  property p_fault_off; switch_fault[0] |-> ##2 !switch_drive[0]; endproperty
  a_fault_off: assert property (p_fault_off) else $error("faulted switch still on");
  property p_ov_off; (supply_ov && !sd_dis_reg[1]) [*6] |-> switch_drive == 4'h0; endproperty
  a_ov_off: assert property (p_ov_off) else $error("switch on during overvoltage");
  property p_uv_off; (supply_uv && !sd_dis_reg[0]) [*6] |-> switch_drive == 4'h0; endproperty
  a_uv_off: assert property (p_uv_off) else $error("switch on during undervoltage");
  property p_select_on;
    (wr_en && addr == HSSC_ADDR_SELECT_A && wr_data[2:0] == HSSC_SRC_ON && !supply_ov
     && !supply_uv && !switch_fault[0] && !soft_reset && !restart_enter)
    ##1 (!switch_fault[0] && !soft_reset) |=> switch_drive[0];
  endproperty
  a_select_on: assert property (p_select_on) else $error("switch one not on");
  property p_reserved_code;
    wr_en && addr == HSSC_ADDR_SELECT_A && wr_data[2:1] == 2'h3 |-> ##2 !switch_drive[0];
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code drives");
  property p_pwm_full; (duty_reg == HSSC_PWM_FULL) [*3] |-> pulse_channel_one_level; endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("full duty not on");
  property p_pwm_zero; (duty_reg == 8'h00) [*3] |-> !pulse_channel_one_level; endproperty
  a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty not off");
  property p_timer_run;
    timer_run[0] |-> cyclic_timer_one_ctrl_in[6:4] inside {[3'h1:3'h5]} && timer_run[3:2] == 2'h0;
  endproperty
  a_timer_run: assert property (p_timer_run) else $error("timer runs on stop code");
  property p_timer_clear; timer_clear |-> $past(restart_enter) && $past(cyclic_sense_active);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("stray timer clear");
  property p_fail_sel; pin1_fail_select == (pin1_func < 3'h4); endproperty
  a_fail_sel: assert property (p_fail_sel) else $error("fail select mismatch");
  c_timer_clear: cover property (timer_clear);
  c_fault: cover property (switch_fault[0] && switch_drive[0]);
  c_uv: cover property (supply_uv [*6]);
endmodule : hssc_bank_chk

bind hssc_bank hssc_bank_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk_sys, .reset_n, .soft_reset, .restart_enter, .cyclic_sense_active, .wr_en, .rd_en,
  .addr, .wr_data, .rd_data, .rd_valid, .cyclic_timer_one_ctrl_in, .timer_clear, .supply_ov,
  .supply_uv, .switch_fault, .switch_drive, .timer_run, .pulse_channel_one_level, .pin1_func,
  .pin1_fail_select
);

/* hssc_load_model.sv */
// partner: switch loads that report overcurrent while driven
`timescale 1ns/10ps
module hssc_load_model (
  input  wire logic [3:0] switch_drive,
  input  wire logic [3:0] short_cmd,
  output logic      [3:0] switch_fault
);
  // a shorted load only draws overcurrent while its switch is on
  assign switch_fault = short_cmd & switch_drive;
endmodule : hssc_load_model

/* tb_top.sv */
// testbench: registers, switch sources, faults and pulse channel one
`timescale 1ns/10ps
module tb_top;
  import hssc_pkg::*;
  localparam int STEP = 2;
  typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] q;} hssc_row_t;
  logic       clk_sys, reset_n, soft_reset, restart_enter, cyclic_sense_active, wr_en, rd_en;
  logic       rd_valid, timer_clear, cyclic_timer_one_level, cyclic_timer_two_level, pulse_channel_two_level, supply_ov;
  logic       supply_uv, pulse_channel_one_level, pin1_fail_select, pin2_fail_select;
  logic [6:0] addr;
  logic [7:0] wr_data, rd_data, cyclic_timer_one_ctrl_in, cyclic_timer_two_ctrl_in;
  logic [3:0] switch_fault, switch_drive, timer_run, short_cmd;
  logic [2:0] pin1_func, pin2_func;
  logic [1:0] fail_output_duty;
  int         n_fail, tests_run, cnt;
  hssc_row_t  rows [7] = '{'{7'h10, 8'hFF, 8'h70}, '{7'h14, 8'hFF, 8'h77},
    '{7'h15, 8'hFF, 8'h77}, '{7'h17, 8'hFF, 8'hFF}, '{7'h18, 8'hA5, 8'hA5},
    '{7'h11, 8'hFF, 8'h00}, '{7'h16, 8'hFF, 8'h00}};
  logic [6:0] regs [5] = '{7'h10, 7'h14, 7'h15, 7'h17, 7'h18};
  logic [7:0] kept [5] = '{8'h70, 8'h00, 8'h00, 8'hFF, 8'hA5};
  logic [7:0] on_tbl [2] = '{8'h36, 8'h0A};
  hssc_bank #(.STEP_CYCLES(STEP)) dut (
    .clk_sys, .reset_n, .soft_reset, .restart_enter, .cyclic_sense_active, .wr_en, .rd_en,
    .addr, .wr_data, .rd_data, .rd_valid, .cyclic_timer_one_ctrl_in, .cyclic_timer_two_ctrl_in, .timer_clear,
    .cyclic_timer_one_level, .cyclic_timer_two_level, .pulse_channel_two_level, .supply_ov, .supply_uv, .switch_fault,
    .switch_drive, .timer_run, .pulse_channel_one_level, .pin1_func, .pin2_func, .fail_output_duty,
    .pin1_fail_select, .pin2_fail_select
  );
  hssc_load_model load (.switch_drive, .short_cmd, .switch_fault);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // --------------------------------
  // tasks
  // --------------------------------
  // inputs always move 1 ns after the edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    tick(1);
    wr_en = 1'b0;
    // one idle edge so a following call never re-raises the strobe in this step
    tick(1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    int i;
    rd_en = 1'b1;
    addr = a;
    tick(1);
    rd_en = 1'b0;
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) tick(1);
    if (i == 4) begin
      n_fail++;
      report_and_stop();
    end
    chk(rd_data, exp);
    tick(1);
  endtask : rd
  task automatic sel(input logic [2:0] c);
    wr(HSSC_ADDR_SELECT_A, {1'b0, c, 1'b0, c});
    wr(HSSC_ADDR_SELECT_B, {1'b0, c, 1'b0, c});
    tick(2);
  endtask : sel
  task automatic pulse_restart;
    restart_enter = 1'b1;
    tick(1);
    restart_enter = 1'b0;
  endtask : pulse_restart
  // eight cycles covers the supply synchroniser plus the drive register
  task automatic sup(input logic ov, input logic uv, input logic [7:0] exp);
    supply_ov = ov;
    supply_uv = uv;
    tick(8);
    chk({4'h0, switch_drive}, exp);
  endtask : sup
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {soft_reset, restart_enter, cyclic_sense_active, wr_en, rd_en, cyclic_timer_one_level} = '0;
    {cyclic_timer_two_level, pulse_channel_two_level, supply_ov, supply_uv, addr, wr_data, short_cmd} = '0;
    {cyclic_timer_one_ctrl_in, cyclic_timer_two_ctrl_in} = '0;
    n_fail = 0;
    tests_run = 0;
    reset_n = 1'b0;
    tick(5);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, 8'h00);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
    end
    $display("register table done");
    pulse_restart();
    chk({7'h0, timer_clear}, 8'h00);
    foreach (regs[i]) rd(regs[i], kept[i]);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    $display("restart and soft reset done");
    for (int p = 0; p < 2; p++) begin
      cyclic_timer_one_level = (p == 0);
      cyclic_timer_two_level = (p == 1);
      pulse_channel_two_level = (p == 0);
      wr(HSSC_ADDR_PULSE_CHANNEL_ONE_DUTY, (p == 0) ? HSSC_PWM_FULL : 8'h00);
      for (int c = 0; c < 8; c++) begin
        sel(3'(c));
        chk({4'h0, switch_drive}, {4'h0, {4{on_tbl[p][c]}}});
      end
    end
    $display("switch sources done");
    for (int i = 0; i < 8; i++) begin
      wr(HSSC_ADDR_PIN_FUNC, {i[1:0], i[2:0], 3'(7 - i)});
      chk({pin2_fail_select, pin2_func, pin1_fail_select, pin1_func},
          {i < 4, i[2:0], i > 3, 3'(7 - i)});
      chk({6'h0, fail_output_duty}, {6'h0, i[1:0]});
    end
    $display("pin functions done");
    // cyclic sensing needs timer one or timer two on a switch
    cyclic_sense_active = 1'b1;
    wr(HSSC_ADDR_SELECT_A, 8'h02);
    for (int k = 0; k < 8; k++) begin
      cyclic_timer_one_ctrl_in = {1'b0, 3'(k), 4'h1};
      tick(1);
      chk({4'h0, timer_run}, {7'h0, k inside {[1:5]}});
    end
    cyclic_timer_two_ctrl_in = 8'h50;
    wr(HSSC_ADDR_SELECT_A, 8'h32);
    chk({4'h0, timer_run}, 8'h02);
    cyclic_timer_one_ctrl_in = 8'h31;
    wr(HSSC_ADDR_SELECT_A, 8'h00);
    chk({4'h0, timer_run}, 8'h00);
    wr(HSSC_ADDR_SELECT_A, 8'h02);
    pulse_restart();
    chk({7'h0, timer_clear}, 8'h01);
    cyclic_sense_active = 1'b0;
    $display("timers done");
    wr(HSSC_ADDR_SELECT_A, 8'h11);
    short_cmd = 4'h1;
    tick(6);
    chk({4'h0, switch_drive}, 8'h02);
    rd(HSSC_ADDR_SELECT_A, 8'h10);
    short_cmd = 4'h0;
    $display("overcurrent done");
    wr(HSSC_ADDR_SHUTDOWN, 8'h00);
    wr(HSSC_ADDR_SELECT_A, 8'h01);
    sup(1'b1, 1'b0, 8'h00);
    sup(1'b0, 1'b0, 8'h00);
    rd(HSSC_ADDR_SELECT_A, 8'h00);
    wr(HSSC_ADDR_SHUTDOWN, 8'h10);
    wr(HSSC_ADDR_SELECT_A, 8'h01);
    sup(1'b0, 1'b1, 8'h00);
    sup(1'b0, 1'b0, 8'h01);
    wr(HSSC_ADDR_SHUTDOWN, 8'h60);
    sup(1'b1, 1'b1, 8'h01);
    sup(1'b0, 1'b0, 8'h01);
    $display("supply faults done");
    // mid duty only: a duty of one cannot be realised by a real switch
    wr(HSSC_ADDR_PULSE_CHANNEL_ONE_DUTY, 8'h40);
    wr(HSSC_ADDR_SELECT_A, 8'h04);
    tick(4);
    cnt = 0;
    repeat (255 * STEP) begin
      cnt += (switch_drive[0] === 1'b1);
      tick(1);
    end
    chk(cnt[7:0], 8'h80);
    $display("pulse duty done");
    report_and_stop();
  end
endmodule : tb_top
